// >>> common/pcpm_defines.svh
// Offsets, field positions and fixed values of the configuration tail
`ifndef PCPM_DEFINES_SVH
`define PCPM_DEFINES_SVH

// Byte offsets in configuration space
`define PCPM_OFS_INT_PIN 8'h3d
`define PCPM_OFS_MIN_GNT 8'h3e
`define PCPM_OFS_MAX_LAT 8'h3f
`define PCPM_OFS_RSVD 8'h40
`define PCPM_OFS_CAP_KIND 8'h44
`define PCPM_OFS_NEXT_CAP 8'h45
`define PCPM_OFS_PM_CAPS 8'h46

// Dword indices that hold the bytes above
`define PCPM_DW_MISC 6'h0f
`define PCPM_DW_RSVD 6'h10
`define PCPM_DW_CAP 6'h11

// Fixed byte values
`define PCPM_INT_PIN_VAL 8'h01
`define PCPM_MIN_GNT_VAL 8'h00
`define PCPM_MAX_LAT_VAL 8'h00
`define PCPM_CAP_KIND_VAL 8'h01
`define PCPM_CAP_OFF_VAL 8'h00
`define PCPM_NEXT_CAP_VAL 8'h00

// Power capabilities word fields
`define PCPM_WAKE_MASK_VAL 5'h08
`define PCPM_SECOND_SLEEP_OK 1'h0
`define PCPM_FIRST_SLEEP_OK 1'h0
`define PCPM_DYN_POWER_RPT 1'h0
`define PCPM_CAPS_RSVD_VAL 2'h0
`define PCPM_SPECIAL_INIT 1'h0
`define PCPM_AUX_POWER 1'h0
`define PCPM_WAKE_CLK 1'h0
`define PCPM_PM_VERSION 3'h0
`define PCPM_PM_CAPS_OFF 16'h0000

// Vendor control word: capability list enable position
`define PCPM_CAP_EN_BIT 20

// Minimum grant unit and its cycle count at 4 ns
`define PCPM_CLK_PERIOD_NS 4
`define PCPM_GNT_UNIT_NS 250
`define PCPM_GNT_UNIT_CYC ((`PCPM_GNT_UNIT_NS + `PCPM_CLK_PERIOD_NS - 1) / `PCPM_CLK_PERIOD_NS)

`endif

// >>> common/pcpm_pkg.sv
// Types shared by the configuration tail modules
package pcpm_pkg;
  typedef logic [7:0] pcpm_byte_t;
  typedef logic [5:0] pcpm_dw_t;
  typedef logic [3:0] pcpm_be_t;
  typedef logic [31:0] pcpm_word_t;
  typedef enum logic [1:0] {
    PCPM_REG_NONE,
    PCPM_REG_MISC,
    PCPM_REG_RSVD,
    PCPM_REG_CAP
  } pcpm_region_e;
endpackage

// >>> common/pcpm_req_if.sv
// Carrier for a captured configuration request
`timescale 1ns/1ns
interface pcpm_req_if;
  import pcpm_pkg::*;
  logic valid;
  logic we;
  pcpm_dw_t dw;
  pcpm_be_t be;
  modport src (output valid, output we, output dw, output be);
  modport dst (input valid, input we, input dw, input be);
endinterface

// >>> rtl/pcpm_cfg_capture.sv
// Captures one configuration cycle from the access port
`timescale 1ns/1ns
module pcpm_cfg_capture
  import pcpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Access port
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire pcpm_dw_t cfg_dw_addr,
  input wire pcpm_be_t cfg_be,
  // Captured request
  pcpm_req_if.src req
);
  logic valid_ff;
  logic we_ff;
  pcpm_dw_t dw_ff;
  pcpm_be_t be_ff;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      valid_ff <= 1'b0;
      we_ff <= 1'b0;
      dw_ff <= 6'h00;
      be_ff <= 4'h0;
    end
    else
    begin
      valid_ff <= cfg_req;
      we_ff <= cfg_we;
      dw_ff <= cfg_dw_addr;
      be_ff <= cfg_be;
    end
  end

  assign req.valid = valid_ff;
  assign req.we = we_ff;
  assign req.dw = dw_ff;
  assign req.be = be_ff;
endmodule

// >>> rtl/pcpm_lane.sv
// One byte lane of read data with its claim flag
`timescale 1ns/1ns
module pcpm_lane
  import pcpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Lane select
  input wire logic load,
  input wire logic owned,
  input wire pcpm_byte_t value,
  // Registered result
  output pcpm_byte_t rdata,
  output logic claim
);
  pcpm_byte_t data_ff;
  logic claim_ff;
  pcpm_byte_t nxt_data;
  logic nxt_claim;

  assign nxt_data = (load && owned) ? value : 8'h00;
  assign nxt_claim = load && owned;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      data_ff <= 8'h00;
      claim_ff <= 1'b0;
    end
    else
    begin
      data_ff <= nxt_data;
      claim_ff <= nxt_claim;
    end
  end

  assign rdata = data_ff;
  assign claim = claim_ff;
endmodule

// >>> rtl/pcpm_cfg_tail.sv
// Read-only configuration tail: interrupt pin to power capabilities word
`timescale 1ns/1ns
`include "pcpm_defines.svh"

module pcpm_cfg_tail
  import pcpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration access port
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire pcpm_dw_t cfg_dw_addr,
  input wire pcpm_be_t cfg_be,
  input wire pcpm_word_t cfg_wdata,
  // Vendor control word from the second base address region
  input wire pcpm_word_t vendor_control_word,
  // Answer
  output logic cfg_ack,
  output pcpm_word_t cfg_rdata,
  output pcpm_be_t cfg_claim_be,
  output logic cap_list_enable
);
  pcpm_req_if req();

  pcpm_region_e region;
  logic cap_en;
  logic rd_load;
  logic [3:0] lane_owned;
  logic [3:0] lane_claim;
  pcpm_word_t region_word;
  pcpm_word_t misc_word;
  pcpm_word_t cap_word;
  pcpm_byte_t cap_kind_val;
  logic [15:0] pm_caps_full;
  logic [15:0] pm_caps_val;
  logic [3:0] misc_owned;
  logic ack_ff;
  logic cap_en_ff;
  logic unused_wdata;

  pcpm_cfg_capture u_capture (
    .clk(clk),
    .nrst(nrst),
    .cfg_req(cfg_req),
    .cfg_we(cfg_we),
    .cfg_dw_addr(cfg_dw_addr),
    .cfg_be(cfg_be),
    .req(req)
  );

  // Capability list enable from the vendor control word
  assign cap_en = vendor_control_word[`PCPM_CAP_EN_BIT];

  // Region decode
  assign region = (req.dw == `PCPM_DW_MISC) ? PCPM_REG_MISC :
                  (req.dw == `PCPM_DW_RSVD) ? PCPM_REG_RSVD :
                  (req.dw == `PCPM_DW_CAP) ? PCPM_REG_CAP : PCPM_REG_NONE;

  // Byte 3Ch belongs to the interrupt line register outside this block
  assign misc_owned = 4'he;

  // Interrupt pin, minimum grant, maximum latency
  assign misc_word = {`PCPM_MAX_LAT_VAL,
                      `PCPM_MIN_GNT_VAL,
                      `PCPM_INT_PIN_VAL,
                      8'h00};

  // Capability kind gated by the enable
  assign cap_kind_val = cap_en ? `PCPM_CAP_KIND_VAL : `PCPM_CAP_OFF_VAL;

  // Power management capabilities word
  assign pm_caps_full = {`PCPM_WAKE_MASK_VAL,
                         `PCPM_SECOND_SLEEP_OK,
                         `PCPM_FIRST_SLEEP_OK,
                         `PCPM_DYN_POWER_RPT,
                         `PCPM_CAPS_RSVD_VAL,
                         `PCPM_SPECIAL_INIT,
                         `PCPM_AUX_POWER,
                         `PCPM_WAKE_CLK,
                         `PCPM_PM_VERSION};
  assign pm_caps_val = cap_en ? pm_caps_full : `PCPM_PM_CAPS_OFF;

  assign cap_word = {pm_caps_val, `PCPM_NEXT_CAP_VAL, cap_kind_val};

  // Word and owned lanes for the addressed dword
  always_comb
  begin
    case (region)
      PCPM_REG_MISC:
      begin
        region_word = misc_word;
        lane_owned = misc_owned;
      end
      PCPM_REG_RSVD:
      begin
        region_word = 32'h0000_0000;
        lane_owned = 4'hf;
      end
      PCPM_REG_CAP:
      begin
        region_word = cap_word;
        lane_owned = 4'hf;
      end
      default:
      begin
        region_word = 32'h0000_0000;
        lane_owned = 4'h0;
      end
    endcase
  end

  // Writes are claimed and acknowledged but store nothing
  assign rd_load = req.valid && !req.we;
  assign unused_wdata = ^cfg_wdata;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      pcpm_lane u_lane (
        .clk(clk),
        .nrst(nrst),
        .load(req.valid),
        .owned(lane_owned[gi] && req.be[gi]),
        .value(rd_load ? region_word[gi*8 +: 8] : 8'h00),
        .rdata(cfg_rdata[gi*8 +: 8]),
        .claim(lane_claim[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ack_ff <= 1'b0;
      cap_en_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req.valid;
      cap_en_ff <= cap_en;
    end
  end

  assign cfg_ack = ack_ff;
  assign cfg_claim_be = lane_claim;
  assign cap_list_enable = cap_en_ff;
endmodule

// >>> verification/pcpm_cfg_tail_props.sv
// Assertions on the configuration tail ports
`timescale 1ns/1ns
module pcpm_cfg_tail_props
  import pcpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Access port
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire pcpm_dw_t cfg_dw_addr,
  input wire pcpm_be_t cfg_be,
  input wire pcpm_word_t cfg_wdata,
  input wire pcpm_word_t vendor_control_word,
  // Answer
  input wire logic cfg_ack,
  input wire pcpm_word_t cfg_rdata,
  input wire pcpm_be_t cfg_claim_be,
  input wire logic cap_list_enable
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(d);
    cfg_req && !cfg_we && cfg_be == 4'hf && cfg_dw_addr == d ##2 1'b1;
  endsequence
  a_ack_delay: assert property (cfg_req |-> ##2 cfg_ack) else $error("ack late");
  a_ack_cause: assert property (cfg_ack |-> $past(cfg_req, 2)) else $error("stray ack");
  a_write_silent: assert property (cfg_req && cfg_we |-> ##2 cfg_rdata == 32'h0)
    else $error("write data");
  a_int_pin: assert property (s_rd(6'h0f) |-> cfg_rdata[15:8] == 8'h01)
    else $error("pin byte");
  a_grant_latency: assert property (s_rd(6'h0f) |-> cfg_rdata[31:16] == 16'h0)
    else $error("grant byte");
  a_cap_kind: assert property (s_rd(6'h11) |->
    cfg_rdata[7:0] == {7'h0, $past(vendor_control_word[20])}) else $error("kind");
  a_pm_word: assert property (s_rd(6'h11) |->
    cfg_rdata[31:8] == {1'b0, $past(vendor_control_word[20]), 22'h0}) else $error("word");
  a_enable_copy: assert property ($past(nrst) && $past(nrst, 2) |->
    cap_list_enable == $past(vendor_control_word[20])) else $error("enable copy");
endmodule
bind pcpm_cfg_tail pcpm_cfg_tail_props i_props(.clk(clk), .nrst(nrst), .cfg_req(cfg_req),
  .cfg_we(cfg_we), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .vendor_control_word(vendor_control_word), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
  .cfg_claim_be(cfg_claim_be), .cap_list_enable(cap_list_enable));

// >>> verification/pcpm_host_model.sv
// Host issuing configuration cycles
`timescale 1ns/1ns
module pcpm_host_model
  import pcpm_pkg::*;
(
  // Clock and answer
  input wire logic clk,
  input wire logic ack,
  input wire pcpm_word_t rdata,
  input wire pcpm_be_t claim,
  // Request
  output logic req,
  output logic we,
  output pcpm_dw_t dw,
  output pcpm_be_t be,
  output pcpm_word_t wd
);
  initial
  begin
    req = 1'b0;
    we = 1'b0;
    dw = 6'h0;
    be = 4'h0;
    wd = 32'h0;
  end
  task automatic acc(input logic w, input pcpm_dw_t d, input pcpm_be_t b, output pcpm_word_t rd,
    output pcpm_be_t cb);
    rd = 'x;
    cb = 'x;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    dw <= d;
    be <= b;
    wd <= {d, ~d, d, ~d, 8'h5a};
    @(posedge clk);
    req <= 1'b0;
    we <= ~w;
    dw <= ~d;
    be <= 4'h0;
    wd <= ~wd;
    for (int n = 0; n < 6; n++)
    begin
      @(posedge clk);
      #1;
      if (ack === 1'b1)
      begin
        rd = rdata;
        cb = claim;
        break;
      end
    end
  endtask
endmodule

// >>> verification/pcpm_cfg_tail_tb.sv
// Bench for the configuration tail
`timescale 1ns/1ns
module pcpm_cfg_tail_tb;
  import pcpm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic req, we, ack, cle;
  pcpm_dw_t dw;
  pcpm_be_t be, cb, rcb;
  pcpm_word_t wd, rd, rrd;
  pcpm_word_t vcw = 32'h0;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  pcpm_host_model i_pcpm_host_model(.clk(clk), .ack(ack), .rdata(rd), .claim(cb), .req(req),
    .we(we), .dw(dw), .be(be), .wd(wd));
  pcpm_cfg_tail i_pcpm_cfg_tail(.clk(clk), .nrst(nrst), .cfg_req(req), .cfg_we(we),
    .cfg_dw_addr(dw), .cfg_be(be), .cfg_wdata(wd), .vendor_control_word(vcw), .cfg_ack(ack),
    .cfg_rdata(rd), .cfg_claim_be(cb), .cap_list_enable(cle));
  task check(input pcpm_word_t got, input pcpm_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One access with a given enable; other control bits set when the enable is off to catch a wrong bit
  task run(input logic w, input pcpm_dw_t d, input pcpm_be_t b, input logic en,
    input pcpm_word_t e, input pcpm_be_t c);
    @(posedge clk);
    vcw <= en ? 32'h0010_0000 : 32'hffef_ffff;
    i_pcpm_host_model.acc(w, d, b, rrd, rcb);
    check(rrd, e);
    check({28'h0, rcb}, {28'h0, c});
    check({31'h0, cle}, {31'h0, en});
    $display("Test done dw %h we %b en %b", d, w, en);
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH %0t watchdog", $time);
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check({31'h0, ack}, 32'h0);
    check(rd, 32'h0);
    check({28'h0, cb}, 32'h0);
    run(1'b0, 6'h0f, 4'hf, 1'b1, 32'h0000_0100, 4'he);
    run(1'b0, 6'h11, 4'hf, 1'b1, 32'h4000_0001, 4'hf);
    run(1'b0, 6'h11, 4'hf, 1'b0, 32'h0, 4'hf);
    run(1'b1, 6'h11, 4'hf, 1'b1, 32'h0, 4'hf);
    run(1'b1, 6'h0f, 4'hf, 1'b1, 32'h0, 4'he);
    run(1'b0, 6'h0f, 4'hf, 1'b1, 32'h0000_0100, 4'he);
    run(1'b0, 6'h11, 4'hf, 1'b1, 32'h4000_0001, 4'hf);
    run(1'b0, 6'h10, 4'hf, 1'b1, 32'h0, 4'hf);
    run(1'b0, 6'h12, 4'hf, 1'b1, 32'h0, 4'h0);
    run(1'b0, 6'h11, 4'hc, 1'b1, 32'h4000_0000, 4'hc);
    run(1'b0, 6'h0f, 4'h3, 1'b1, 32'h0000_0100, 4'h2);
    end_of_test;
  end
endmodule
